// *** cmp_pkg.sv ***
// constants, field layouts and carrier types of the comparator register bank
// assumes a 32-bit apb slave port and a digital view of the analog core
// How it works
// [RULE1] four event flags, set by hardware, write-0 clears
// [RULE2] crossing flags at 0x104, 0x108, 0x10c
// [RULE3] link bit 0: ready triggers sample
// [RULE4] link bit 1: ready triggers stop
// [RULE5] link bit 2: falling crossing triggers stop
// [RULE6] link bit 3: rising crossing triggers stop
// [RULE7] link bit 4: any crossing triggers stop
// [RULE8] irq enable bits for four events
// [RULE9] set alias writes ones, reads enables
// [RULE10] clear alias clears ones, reads enables
// [RULE11] sample task latches compare output
// [RULE12] enable field: 0 off, 2 on
// [RULE13] positive input select, 7 means half supply
// [RULE14] reference choice resets to four
// [RULE15] ready raised after start-up time
// [RULE16] crossings raise rising, falling, any events
// [RULE17] irq high while enabled flag set
// [RULE18] undefined bits read zero
`default_nettype none
package cmp_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [11:0] OFF_TASK_START = 12'h000;
    localparam logic [11:0] OFF_TASK_STOP = 12'h004;
    localparam logic [11:0] OFF_TASK_SAMPLE = 12'h008;
    localparam logic [11:0] OFF_READY_FLAG = 12'h100;
    localparam logic [11:0] OFF_FALL_FLAG = 12'h104;
    localparam logic [11:0] OFF_RISE_FLAG = 12'h108;
    localparam logic [11:0] OFF_ANY_FLAG = 12'h10c;
    localparam logic [11:0] OFF_LINKS = 12'h200;
    localparam logic [11:0] OFF_IRQ_EN = 12'h300;
    localparam logic [11:0] OFF_IRQ_SET = 12'h304;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFF_OUTCOME = 12'h400;
    localparam logic [11:0] OFF_ON_OFF = 12'h500;
    localparam logic [11:0] OFF_POS_ROUTE = 12'h504;
    localparam logic [11:0] OFF_REF_CHOICE = 12'h508;

    // ----------------------------------------
    // field values and bit positions
    // ----------------------------------------
    localparam int EV_READY = 0;
    localparam int EV_FALL = 1;
    localparam int EV_RISE = 2;
    localparam int EV_ANY = 3;
    localparam int LNK_READY_SAMPLE = 0;
    localparam int LNK_READY_HALT = 1;
    localparam int LNK_FALL_HALT = 2;
    localparam int LNK_RISE_HALT = 3;
    localparam int crossing_triggers_halt = 4;
    localparam logic [1:0] ON_OFF_DISABLED = 2'h0;
    localparam logic [1:0] ON_OFF_ENABLED = 2'h2;
    localparam logic [2:0] half_supply_input = 3'h7;
    localparam logic [2:0] POS_ROUTE_RESET = 3'h0;
    localparam logic [2:0] REF_CHOICE_RESET = 3'h4;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int STARTUP_NS = 3000;
    localparam int STARTUP_CYCLES = (STARTUP_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        CORE_IDLE = 2'b00,
        CORE_WARM = 2'b01,
        CORE_RUN = 2'b10
    } core_e;

    typedef struct packed {
        logic [31:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        core_e phase;
        logic [11:0] warm_cnt;
        logic [3:0] flags;
        logic [4:0] links;
        logic [3:0] irq_en;
        logic outcome;
        logic [1:0] on_off;
        logic [2:0] pos_route;
        logic [2:0] ref_choice;
        logic cmp_last;
        logic [2:0] cmp_sync;
        logic [31:0] prdata;
    } state_s;

endpackage : cmp_pkg
`default_nettype wire

// *** cmp_regs.sv ***
// comparator control register bank: apb slave, event flags, shortcuts, irq
// assumes cmp_level is the asynchronous digital output of the analog core
`timescale 1ns/1ns
`default_nettype none
module cmp_regs
    import cmp_pkg::*;
#(
    parameter int WARM_CYCLES = STARTUP_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog core
    input wire logic cmp_level,
    output logic core_on,
    output logic [2:0] pos_route,
    output logic [2:0] ref_choice,
    // interrupt
    output logic irq
);

    state_s s_r;
    state_s s_nxt;
    apb_req_s req;
    logic wr;
    logic rd;
    logic [11:0] off;
    logic mapped;
    logic start_task;
    logic stop_task;
    logic sample_task;
    logic [3:0] ev;
    logic cmp_now;

    assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
    assign off = req.paddr[11:0];
    assign wr = psel && penable && req.pwrite;
    assign rd = psel && !penable && !req.pwrite;
    assign pready = 1'b1;
    assign prdata = s_r.prdata;
    assign core_on = (s_r.phase != CORE_IDLE);
    assign pos_route = s_r.pos_route;
    assign ref_choice = s_r.ref_choice;
    assign irq = |(s_r.flags & s_r.irq_en); // RULE17

    function automatic logic is_mapped(input logic [31:0] a);
        logic [11:0] o;
        o = a[11:0];
        is_mapped = (a[31:12] == 20'h0) && (o == OFF_TASK_START || o == OFF_TASK_STOP
            || o == OFF_TASK_SAMPLE || o == OFF_READY_FLAG || o == OFF_FALL_FLAG
            || o == OFF_RISE_FLAG || o == OFF_ANY_FLAG || o == OFF_LINKS
            || o == OFF_IRQ_EN || o == OFF_IRQ_SET || o == OFF_IRQ_CLR
            || o == OFF_OUTCOME || o == OFF_ON_OFF || o == OFF_POS_ROUTE
            || o == OFF_REF_CHOICE);
    endfunction : is_mapped

    assign mapped = is_mapped(req.paddr);
    assign pslverr = psel && penable && !mapped;

    // three-stage input; a change counts when stages two and three agree
    assign cmp_now = s_r.cmp_sync[2];

    always_comb begin
        s_nxt = s_r;
        s_nxt.cmp_sync = {s_r.cmp_sync[1:0], cmp_level};
        start_task = wr && mapped && off == OFF_TASK_START && req.pwdata[0];
        stop_task = wr && mapped && off == OFF_TASK_STOP && req.pwdata[0];
        sample_task = wr && mapped && off == OFF_TASK_SAMPLE && req.pwdata[0];
        ev = 4'h0;

        // ----------------------------------------
        // core sequencing
        // ----------------------------------------
        unique case (s_r.phase)
            CORE_IDLE: begin
                if (start_task && s_r.on_off == ON_OFF_ENABLED) begin
                    s_nxt.phase = CORE_WARM;
                    s_nxt.warm_cnt = 12'h0;
                end
            end
            CORE_WARM: begin
                if (s_r.warm_cnt == 12'(WARM_CYCLES - 1)) begin
                    ev[EV_READY] = 1'b1; // RULE15
                    s_nxt.phase = CORE_RUN;
                    s_nxt.cmp_last = cmp_now;
                end else begin
                    s_nxt.warm_cnt = s_r.warm_cnt + 12'h1;
                end
            end
            CORE_RUN: begin
                if (s_r.cmp_sync[2] == s_r.cmp_sync[1] && cmp_now != s_r.cmp_last) begin
                    s_nxt.cmp_last = cmp_now;
                    ev[EV_RISE] = cmp_now; // RULE16
                    ev[EV_FALL] = !cmp_now; // RULE16
                    ev[EV_ANY] = 1'b1; // RULE16
                end
            end
        endcase

        // ----------------------------------------
        // shortcuts and tasks
        // ----------------------------------------
        if (s_r.links[LNK_READY_SAMPLE] && ev[EV_READY]) begin // RULE3
            sample_task = 1'b1;
        end
        if ((s_r.links[LNK_READY_HALT] && ev[EV_READY]) // RULE4
            || (s_r.links[LNK_FALL_HALT] && ev[EV_FALL]) // RULE5
            || (s_r.links[LNK_RISE_HALT] && ev[EV_RISE]) // RULE6
            || (s_r.links[crossing_triggers_halt] && ev[EV_ANY])) begin // RULE7
            stop_task = 1'b1;
        end
        if (stop_task) begin
            s_nxt.phase = CORE_IDLE;
        end
        if (sample_task) begin
            s_nxt.outcome = cmp_now; // RULE11
        end
        if (wr && mapped && off == OFF_ON_OFF && req.pwdata[1:0] == ON_OFF_DISABLED) begin
            s_nxt.phase = CORE_IDLE;
        end

        // ----------------------------------------
        // register writes; hardware set wins over clear
        // ----------------------------------------
        if (wr && mapped) begin
            unique case (off)
                OFF_READY_FLAG: if (!req.pwdata[0]) s_nxt.flags[EV_READY] = 1'b0; // RULE1
                OFF_FALL_FLAG: if (!req.pwdata[0]) s_nxt.flags[EV_FALL] = 1'b0; // RULE2
                OFF_RISE_FLAG: if (!req.pwdata[0]) s_nxt.flags[EV_RISE] = 1'b0; // RULE2
                OFF_ANY_FLAG: if (!req.pwdata[0]) s_nxt.flags[EV_ANY] = 1'b0; // RULE2
                OFF_LINKS: s_nxt.links = req.pwdata[4:0];
                OFF_IRQ_EN: s_nxt.irq_en = req.pwdata[3:0]; // RULE8
                OFF_IRQ_SET: s_nxt.irq_en = s_r.irq_en | req.pwdata[3:0]; // RULE9
                OFF_IRQ_CLR: s_nxt.irq_en = s_r.irq_en & ~req.pwdata[3:0]; // RULE10
                OFF_ON_OFF: s_nxt.on_off = req.pwdata[1:0]; // RULE12
                OFF_POS_ROUTE: s_nxt.pos_route = req.pwdata[2:0]; // RULE13
                OFF_REF_CHOICE: s_nxt.ref_choice = req.pwdata[2:0];
                default: ;
            endcase
        end
        s_nxt.flags = s_nxt.flags | ev; // RULE1

        // ----------------------------------------
        // read data, captured in setup phase
        // ----------------------------------------
        if (rd) begin
            s_nxt.prdata = 32'h0; // RULE18
            // unmapped aliases of a register offset must read zero too
            case (mapped ? off : 12'hfff)
                OFF_READY_FLAG: s_nxt.prdata[0] = s_r.flags[EV_READY];
                OFF_FALL_FLAG: s_nxt.prdata[0] = s_r.flags[EV_FALL];
                OFF_RISE_FLAG: s_nxt.prdata[0] = s_r.flags[EV_RISE];
                OFF_ANY_FLAG: s_nxt.prdata[0] = s_r.flags[EV_ANY];
                OFF_LINKS: s_nxt.prdata[4:0] = s_r.links;
                OFF_IRQ_EN, OFF_IRQ_SET, OFF_IRQ_CLR: s_nxt.prdata[3:0] = s_r.irq_en; // RULE9
                OFF_OUTCOME: s_nxt.prdata[0] = s_r.outcome;
                OFF_ON_OFF: s_nxt.prdata[1:0] = s_r.on_off;
                OFF_POS_ROUTE: s_nxt.prdata[2:0] = s_r.pos_route;
                OFF_REF_CHOICE: s_nxt.prdata[2:0] = s_r.ref_choice;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{phase: CORE_IDLE, warm_cnt: 12'h0, flags: 4'h0, links: 5'h0,
                irq_en: 4'h0, outcome: 1'b0, on_off: ON_OFF_DISABLED,
                pos_route: POS_ROUTE_RESET, ref_choice: REF_CHOICE_RESET, // RULE14
                cmp_last: 1'b0, cmp_sync: 3'h0, prdata: 32'h0};
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : cmp_regs
`default_nettype wire

// *** cmp_regs_chk.sv ***
// port checker of the comparator register bank
// assumes it is bound to every cmp_regs instance
`timescale 1ns/1ns
`default_nettype none
module cmp_regs_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // core and irq
    input wire logic core_on,
    input wire logic [2:0] pos_route,
    input wire logic [2:0] ref_choice,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wr = psel && penable && pwrite;
    wire logic start_wr = wr && paddr == 32'h0 && pwdata[0];
    chk_ref_reset: assert property ($rose(presetn) |-> ref_choice == 3'h4)
        else $error("ref reset");
    chk_out_reset: assert property ($rose(presetn) |-> !pos_route && !core_on && !irq)
        else $error("out reset");
    chk_pos_write: assert property (wr && paddr == 32'h504 |=> pos_route == $past(pwdata[2:0]))
        else $error("pos write");
    chk_ref_write: assert property (wr && paddr == 32'h508 |=> ref_choice == $past(pwdata[2:0]))
        else $error("ref write");
    chk_bad_addr: assert property (psel && penable && paddr[31:12] != 20'h0 |-> pslverr)
        else $error("no slverr");
    chk_off_write: assert property (wr && paddr == 32'h500 && !pwdata[1:0] |=> !core_on)
        else $error("core stays on");
    chk_start_cause: assert property ($rose(core_on) |-> $past(start_wr))
        else $error("core on unasked");
    chk_irq_masked: assert property (wr && paddr == 32'h300 && !pwdata[3:0] |=> !irq)
        else $error("irq while masked");
    chk_clr_alias: assert property (wr && paddr == 32'h308 && pwdata[3:0] == 4'hf |=> !irq)
        else $error("irq after clear");
endmodule : cmp_regs_chk
bind cmp_regs cmp_regs_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .core_on(core_on), .pos_route(pos_route), .ref_choice(ref_choice), .irq(irq));
`default_nettype wire

// *** tb_comparator_control_registers.sv ***
// self-checking bench of the comparator register bank over apb
// assumes cmp_regs with a short warm-up count and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb_comparator_control_registers;
    localparam int WARM = 4;
    logic pclk, presetn, psel, penable, pwrite, cmp_level, pready, pslverr, core_on, irq;
    logic [31:0] paddr, pwdata, prdata;
    logic [2:0] pos_route, ref_choice;
    int failures, comparisons, cycles;
    logic last_err;
    cmp_regs #(.WARM_CYCLES(WARM)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_level(cmp_level), .core_on(core_on),
        .pos_route(pos_route), .ref_choice(ref_choice), .irq(irq));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // the master waits for pready, never assuming zero wait states
    task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [31:0] a, exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask : settle
    task automatic t_reset_and_config();
        rd(32'h104, 32'h0);
        rd(32'h108, 32'h0);
        rd(32'h10c, 32'h0);
        rd(32'h200, 32'h0);
        rd(32'h508, 32'h4);
        wr(32'h504, 32'hffffffff);
        check(last_err, 32'h0);
        check(pready, 32'h1);
        rd(32'h504, 32'h7);
        check(pos_route, 32'h7);
        wr(32'h508, 32'h5);
        rd(32'h508, 32'h5);
        check(ref_choice, 32'h5);
        wr(32'h600, 32'h1);
        check(last_err, 32'h1);
        rd(32'h600, 32'h0);
        wr(32'h1504, 32'h0);
        check(last_err, 32'h1);
        rd(32'h1504, 32'h0);
        rd(32'h504, 32'h7);
        wr(32'h400, 32'h1);
        rd(32'h400, 32'h0);
    endtask : t_reset_and_config
    task automatic t_irq_aliases();
        wr(32'h300, 32'hffffffff);
        rd(32'h300, 32'hf);
        wr(32'h308, 32'h5);
        rd(32'h308, 32'ha);
        wr(32'h304, 32'h1);
        rd(32'h304, 32'hb);
        wr(32'h308, 32'hf);
        rd(32'h300, 32'h0);
    endtask : t_irq_aliases
    task automatic t_ready_sample();
        cmp_level <= 1'b1;
        wr(32'h500, 32'h1);
        wr(32'h0, 32'h1);
        settle(WARM + 6);
        check(core_on, 32'h0);
        wr(32'h500, 32'h2);
        wr(32'h200, 32'h1);
        wr(32'h300, 32'h1);
        wr(32'h0, 32'h1);
        settle(WARM + 6);
        check(irq, 32'h1);
        rd(32'h400, 32'h1);
        wr(32'h300, 32'h0);
        settle(1);
        check(irq, 32'h0);
        wr(32'h304, 32'h1);
        settle(1);
        check(irq, 32'h1);
        wr(32'h100, 32'h0);
        settle(1);
        check(irq, 32'h0);
    endtask : t_ready_sample
    task automatic t_crossing_triggers_halt(input logic lvl, input logic [31:0] link, up);
        wr(32'h200, link);
        cmp_level <= lvl;
        settle(8);
        check(core_on, 32'h0);
        rd(32'h104, {31'h0, !up});
        rd(32'h108, up);
        rd(32'h10c, 32'h1);
        wr(32'h104, 32'h0);
        wr(32'h108, 32'h0);
        wr(32'h10c, 32'h0);
        wr(32'h200, 32'h2);
        wr(32'h0, 32'h1);
        settle(WARM + 6);
        check(core_on, 32'h0);
        rd(32'h100, 32'h1);
        wr(32'h500, 32'h2);
        wr(32'h200, 32'h0);
        wr(32'h0, 32'h1);
        settle(WARM + 6);
    endtask : t_crossing_triggers_halt
    task automatic print_verdict();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, cmp_level, paddr, pwdata} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_and_config();
        t_irq_aliases();
        t_ready_sample();
        t_crossing_triggers_halt(1'b0, 32'h4, 32'h0);
        t_crossing_triggers_halt(1'b1, 32'h8, 32'h1);
        t_crossing_triggers_halt(1'b0, 32'h10, 32'h0);
        wr(32'h500, 32'h0);
        settle(1);
        check(core_on, 32'h0);
        print_verdict();
    end
endmodule : tb_comparator_control_registers
`default_nettype wire
